// [inc/sfq_params.svh]
// Constants for the serial frame-format and transmit-queue block.
`ifndef SFQ_PARAMS_SVH
`define SFQ_PARAMS_SVH

// Bus clock period in nanoseconds (40 MHz).
`define SFQ_CLK_PERIOD_NS 25

// Transfer shape.
`define SFQ_DATA_BITS 8
`define SFQ_FIFO_DEPTH 8

// Rate select codes, high bit first.
`define SFQ_RATE_DIV2 2'h0
`define SFQ_RATE_DIV8 2'h1
`define SFQ_RATE_DIV32 2'h2
`define SFQ_RATE_DIVIDE_BY_128_RATE 2'h3

// Bus cycles per half serial bit for each rate.
`define SFQ_HALF_DIV2 7'h01
`define SFQ_HALF_DIV8 7'h04
`define SFQ_HALF_DIV32 7'h10
`define SFQ_HALF_DIVIDE_BY_128_RATE 7'h40

`endif

// [inc/sfq_pkg.sv]
// Types shared by the serial frame-format and transmit-queue block.
package sfq_pkg;

  typedef enum logic {
    SFQ_IDLE,
    SFQ_RUN
  } sfq_state_type;

endpackage : sfq_pkg

// [verilog/sfq_sync.sv]
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module sfq_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule : sfq_sync

// [verilog/sfq_fifo.sv]
// Transmit queue FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sfq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    o_in_ready = (count != CW'(DEPTH));
    o_out_valid = (count != '0);
    o_out_data = mem[rd_ptr];
    push = i_in_valid & o_in_ready;
    pop = o_out_valid & i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push) begin
        mem[wr_ptr] <= i_in_data;
      end
    end
  end

endmodule : sfq_fifo

// [verilog/sfq_spi_core.sv]
// Serial interface core: frame formats, rate divider and transmit queue.
`timescale 1ns/1ps
`include "sfq_params.svh"
module sfq_spi_core
  import sfq_pkg::*;
#(
  parameter int DATA_W = `SFQ_DATA_BITS,
  parameter int FIFO_DEPTH = `SFQ_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control bits
  input wire logic i_module_enable,
  input wire logic i_master_select,
  input wire logic i_clock_polarity,
  input wire logic i_clock_phase,
  input wire logic i_rate_select_high,
  input wire logic i_rate_select_low,
  // Transmit queue
  input wire logic i_tx_valid,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_transmit_empty_flag,
  // Receive data
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_receive_full_flag,
  input wire logic i_rx_ack,
  // Status
  output logic o_busy,
  // Serial clock pin
  input wire logic i_sclk_pin,
  output logic o_sclk_pin,
  output logic o_sclk_oe_n,
  // Master out, slave in pin
  input wire logic i_mosi_pin,
  output logic o_mosi_pin,
  output logic o_mosi_oe_n,
  // Master in, slave out pin
  input wire logic i_miso_pin,
  output logic o_miso_pin,
  output logic o_miso_oe_n,
  // Slave select pin
  input wire logic i_ss_n_pin
);

  localparam int STEP_W = $clog2(2 * DATA_W);
  localparam int BIT_W = $clog2(DATA_W);
  localparam logic [STEP_W-1:0] LAST_STEP = STEP_W'(2 * DATA_W - 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(DATA_W - 1);

  // Half serial bit in bus cycles for a rate code.
  function automatic logic [6:0] rate_half(input logic [1:0] sel);
    logic [6:0] half;
    half = `SFQ_HALF_DIV2;
    unique case (sel)
      `SFQ_RATE_DIV2: half = `SFQ_HALF_DIV2;
      `SFQ_RATE_DIV8: half = `SFQ_HALF_DIV8;
      `SFQ_RATE_DIV32: half = `SFQ_HALF_DIV32;
      `SFQ_RATE_DIVIDE_BY_128_RATE: half = `SFQ_HALF_DIVIDE_BY_128_RATE;
    endcase
    return half;
  endfunction : rate_half

  // Pin synchronisation.
  logic [3:0] pin_s;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;

  sfq_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    // Select crosses inverted so that the reset value reads as deselected.
    .i_async({i_sclk_pin, i_mosi_pin, i_miso_pin, ~i_ss_n_pin}),
    .o_sync(pin_s)
  );

  assign sclk_s = pin_s[3];
  assign mosi_s = pin_s[2];
  assign miso_s = pin_s[1];
  assign ss_n_s = ~pin_s[0];

  // Transmit queue.
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic load;

  sfq_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_transmit_empty_flag),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(load)
  );

  // Rate divider.
  logic div_on;
  logic [6:0] half_lim;
  logic [6:0] div_cnt;
  logic [6:0] next_div_cnt;
  logic bound_half;
  logic next_bound_half;
  logic tick;
  logic boundary;

  always_comb begin
    div_on = i_module_enable & i_master_select;
    half_lim = rate_half({i_rate_select_high, i_rate_select_low});
    next_div_cnt = div_cnt + 7'h01;
    next_bound_half = bound_half;
    tick = 1'b0;
    if (!div_on) begin
      next_div_cnt = 7'h00;
      next_bound_half = 1'b0;
    end else if (div_cnt == half_lim - 7'h01) begin
      next_div_cnt = 7'h00;
      next_bound_half = ~bound_half;
      tick = 1'b1;
    end
    boundary = tick & bound_half;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt <= 7'h00;
      bound_half <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      bound_half <= next_bound_half;
    end
  end

  // Transfer engine.
  sfq_state_type state;
  sfq_state_type next_state;
  logic [STEP_W-1:0] step;
  logic [STEP_W-1:0] next_step;
  logic [BIT_W-1:0] bit_cnt;
  logic [BIT_W-1:0] next_bit_cnt;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] next_shift_reg;
  logic shift_full;
  logic next_shift_full;
  logic rx_bit;
  logic next_rx_bit;
  logic sclk_prev;
  logic next_sclk_prev;
  logic ss_prev;
  logic next_ss_prev;
  logic sclk_act;
  logic lead;
  logic trail;
  logic ss_fall;
  logic done;
  logic [DATA_W-1:0] done_word;
  logic [DATA_W-1:0] shifted;

  always_comb begin
    next_state = state;
    next_step = step;
    next_bit_cnt = bit_cnt;
    next_shift_reg = shift_reg;
    next_shift_full = shift_full;
    next_rx_bit = rx_bit;
    load = 1'b0;
    done = 1'b0;
    shifted = {shift_reg[DATA_W-2:0], rx_bit};
    done_word = shifted;
    sclk_act = sclk_s ^ i_clock_polarity;
    lead = sclk_act & ~sclk_prev;
    trail = ~sclk_act & sclk_prev;
    ss_fall = ss_prev & ~ss_n_s;
    next_sclk_prev = sclk_act;
    next_ss_prev = ss_n_s;
    if (!i_module_enable) begin
      next_state = SFQ_IDLE;
      next_step = '0;
      next_bit_cnt = '0;
      next_shift_full = 1'b0;
    end else begin
      unique case (state)
        SFQ_IDLE: begin
          if (!shift_full && fifo_valid) begin
            load = 1'b1;
          end
          if (i_master_select) begin
            // Waits one bit time at most.
            if (shift_full && boundary) begin
              next_state = SFQ_RUN;
              next_step = '0;
            end
          end else if (!i_clock_phase && ss_fall) begin
            next_state = SFQ_RUN;
            next_bit_cnt = '0;
          end else if (i_clock_phase && !ss_n_s && lead) begin
            next_state = SFQ_RUN;
            next_bit_cnt = '0;
          end
        end
        SFQ_RUN: begin
          if (i_master_select) begin
            if (tick) begin
              if (step == LAST_STEP) begin
                done = 1'b1;
                if (fifo_valid) begin
                  load = 1'b1;
                  next_step = '0;
                end else begin
                  next_state = SFQ_IDLE;
                end
              end else begin
                next_step = step + STEP_W'(1);
                if (!step[0]) begin
                  next_rx_bit = miso_s;
                end else begin
                  next_shift_reg = shifted;
                end
              end
            end
          end else if (ss_n_s) begin
            // Deselect aborts and ignores further clocks.
            next_state = SFQ_IDLE;
          end else if (!i_clock_phase) begin
            if (lead) begin
              next_rx_bit = mosi_s;
            end else if (trail) begin
              if (bit_cnt == LAST_BIT) begin
                done = 1'b1;
                next_state = SFQ_IDLE;
              end else begin
                next_shift_reg = shifted;
                next_bit_cnt = bit_cnt + BIT_W'(1);
              end
            end
          end else begin
            if (lead) begin
              next_shift_reg = shifted;
            end else if (trail) begin
              next_rx_bit = mosi_s;
              if (bit_cnt == LAST_BIT) begin
                done = 1'b1;
                done_word = {shift_reg[DATA_W-2:0], mosi_s};
                next_state = SFQ_IDLE;
              end else begin
                next_bit_cnt = bit_cnt + BIT_W'(1);
              end
            end
          end
        end
      endcase
      if (done) begin
        next_shift_reg = done_word;
        next_shift_full = 1'b0;
      end
      // Loads only when idle or finished.
      if (load) begin
        next_shift_reg = fifo_data;
        next_shift_full = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= SFQ_IDLE;
      step <= '0;
      bit_cnt <= '0;
      shift_reg <= '0;
      shift_full <= 1'b0;
      rx_bit <= 1'b0;
      sclk_prev <= 1'b0;
      ss_prev <= 1'b1;
    end else begin
      state <= next_state;
      step <= next_step;
      bit_cnt <= next_bit_cnt;
      shift_reg <= next_shift_reg;
      shift_full <= next_shift_full;
      rx_bit <= next_rx_bit;
      sclk_prev <= next_sclk_prev;
      ss_prev <= next_ss_prev;
    end
  end

  // Receive register and flag.
  logic [DATA_W-1:0] next_rx_data;
  logic next_rx_full;

  always_comb begin
    next_rx_data = o_rx_data;
    next_rx_full = (o_receive_full_flag & ~i_rx_ack) | done;
    if (done) begin
      next_rx_data = done_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rx_data <= '0;
      o_receive_full_flag <= 1'b0;
    end else begin
      o_rx_data <= next_rx_data;
      o_receive_full_flag <= next_rx_full;
    end
  end

  // Pin drive.
  logic master_run;

  always_comb begin
    master_run = div_on & (state == SFQ_RUN);
    o_busy = (state == SFQ_RUN);
    // Phase 0 idle first half, phase 1 edge.
    // Edges leave on the rising bus edge.
    o_sclk_pin = i_clock_polarity ^
      (master_run & (i_clock_phase ? ~step[0] : step[0]));
    o_sclk_oe_n = ~div_on;
    o_mosi_pin = shift_reg[DATA_W-1];
    o_mosi_oe_n = ~div_on;
    o_miso_pin = shift_reg[DATA_W-1];
    o_miso_oe_n = ~(i_module_enable & ~i_master_select & ~ss_n_s);
  end

  // Checks.
  logic [7:0] wait_cnt;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !(div_on && state == SFQ_IDLE && shift_full)) begin
      wait_cnt <= 8'h00;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_master_start;
    state == SFQ_IDLE && div_on && shift_full && boundary;
  endsequence

  sequence s_slave_fall;
    state == SFQ_IDLE && i_module_enable && !i_master_select &&
      !i_clock_phase && ss_fall;
  endsequence

  a_miso_select: assert property (
    ss_n_s |-> o_miso_oe_n) else $error("MISO driven while deselected");

  a_master_start: assert property (
    s_master_start |=> state == SFQ_RUN && step == '0)
    else $error("Master did not start at boundary");

  a_start_delay: assert property (
    wait_cnt < {half_lim, 1'b0}) else $error("Start delay over one bit");

  a_phase0_idle: assert property (
    s_master_start ##1 !i_clock_phase |-> o_sclk_pin == i_clock_polarity)
    else $error("Phase 0 clock left idle too early");

  a_phase1_edge: assert property (
    s_master_start ##1 i_clock_phase |-> o_sclk_pin != i_clock_polarity)
    else $error("Phase 1 first edge missing");

  a_idle_level: assert property (
    state == SFQ_IDLE |-> o_sclk_pin == i_clock_polarity)
    else $error("Clock not at idle level");

  a_no_busy_load: assert property (
    state == SFQ_RUN && !done |-> !load) else $error("Load during transfer");

  a_rx_full_set: assert property (
    done |=> o_receive_full_flag && o_rx_data == $past(done_word))
    else $error("Receive flag or data not updated");

  a_div_stopped: assert property (
    !div_on |-> !tick ##1 div_cnt == 7'h00) else $error("Divider ran");

  a_back_to_back: assert property (
    done && i_master_select && fifo_valid |=> state == SFQ_RUN && shift_full)
    else $error("Queued byte not sent at once");

  a_slave_start0: assert property (
    s_slave_fall ##1 !ss_n_s |-> state == SFQ_RUN)
    else $error("Select fall did not start slave");

endmodule : sfq_spi_core

// [testbench/sfq_dev_model.sv]
// Behavioural serial device that answers the master on the far side.
`timescale 1ns/1ps
module sfq_dev_model (
  // Serial lines
  input wire logic i_sclk,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  output logic o_miso,
  // Format and data
  input wire logic i_clock_polarity_bit,
  input wire logic i_clock_phase_bit,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  logic [3:0] n = 4'h0;
  wire lead = i_sclk ^ i_clock_polarity_bit;
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
  end
  task automatic take();
    sh = {sh[6:0], i_mosi};
    n = n + 4'h1;
    if (n == 4'h8) begin
      o_rx = sh;
      n = 4'h0;
    end
  endtask : take
  // The byte is loaded at select fall; phase 0 shows the MSB.
  always @(negedge i_ss_n) begin
    sh = i_tx;
    n = 4'h0;
    if (!i_clock_phase_bit) o_miso = sh[7];
  end
  // A released line shows the inverse of its last level.
  always @(posedge i_ss_n) o_miso = ~o_miso;
  // Phase 0 samples on the leading edge, phase 1 drives.
  always @(posedge lead) begin
    if (!i_ss_n && i_clock_phase_bit) o_miso = sh[7];
    else if (!i_ss_n) take();
  end
  // The trailing edge does the opposite half of the work.
  always @(negedge lead) begin
    if (!i_ss_n && i_clock_phase_bit) take();
    else if (!i_ss_n) o_miso = sh[7];
  end
endmodule : sfq_dev_model

// [testbench/tb.sv]
// Self-checking bench: master core, slave core and a device model.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [1:0] rate;
    logic tgt;
    logic [7:0] mtx;
    logic [7:0] stx;
  } sfq_row_type;
  localparam int LIM = 4000;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
  logic rh = 1'b0, rl = 1'b0, mv = 1'b0, sv = 1'b0;
  logic mack = 1'b0, sack = 1'b0, ss_a = 1'b1, ss_b = 1'b1;
  logic [7:0] md = 8'h00, sd = 8'h00;
  logic m_txe, m_rxf, m_busy, m_sclk, m_sclk_oe_n, m_mosi, m_mosi_oe_n;
  logic s_rxf, s_miso, s_miso_oe_n, d_miso;
  logic [7:0] m_rx, s_rx, d_rx;
  int i, k, acc, gap, checked = 0, n_fail = 0;
  wire sclk = m_sclk;
  wire mosi = m_mosi;
  wire miso = s_miso_oe_n ? d_miso : s_miso;
  sfq_row_type rows [6] = '{
    {1'b0, 1'b0, 2'h1, 1'b0, 8'hA5, 8'h3C},
    {1'b1, 1'b0, 2'h2, 1'b0, 8'h5A, 8'hC3},
    {1'b0, 1'b1, 2'h3, 1'b0, 8'h81, 8'h7E},
    {1'b1, 1'b1, 2'h0, 1'b0, 8'h0F, 8'hF0},
    {1'b0, 1'b0, 2'h2, 1'b1, 8'h96, 8'h69},
    {1'b1, 1'b1, 2'h2, 1'b1, 8'hE1, 8'h1E}
  };
  always #12.5 clk = ~clk;
  // The master's select input is held high.
  sfq_spi_core sfq_spi_core_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_module_enable(en),
    .i_master_select(1'b1), .i_clock_polarity(clock_polarity_bit),
    .i_clock_phase(clock_phase_bit), .i_rate_select_high(rh),
    .i_rate_select_low(rl), .i_tx_valid(mv), .i_tx_data(md),
    .o_transmit_empty_flag(m_txe), .o_rx_data(m_rx),
    .o_receive_full_flag(m_rxf), .i_rx_ack(mack), .o_busy(m_busy),
    .i_sclk_pin(sclk), .o_sclk_pin(m_sclk), .o_sclk_oe_n(m_sclk_oe_n),
    .i_mosi_pin(mosi), .o_mosi_pin(m_mosi), .o_mosi_oe_n(m_mosi_oe_n),
    .i_miso_pin(miso), .o_miso_pin(), .o_miso_oe_n(),
    .i_ss_n_pin(1'b1)
  );
  sfq_spi_core sfq_spi_core_inst_s (
    .i_clk(clk), .i_sys_rst(rst), .i_module_enable(en),
    .i_master_select(1'b0), .i_clock_polarity(clock_polarity_bit),
    .i_clock_phase(clock_phase_bit), .i_rate_select_high(rh),
    .i_rate_select_low(rl), .i_tx_valid(sv), .i_tx_data(sd),
    .o_transmit_empty_flag(), .o_rx_data(s_rx),
    .o_receive_full_flag(s_rxf), .i_rx_ack(sack), .o_busy(),
    .i_sclk_pin(sclk), .o_sclk_pin(), .o_sclk_oe_n(),
    .i_mosi_pin(mosi), .o_mosi_pin(), .o_mosi_oe_n(),
    .i_miso_pin(miso), .o_miso_pin(s_miso), .o_miso_oe_n(s_miso_oe_n),
    .i_ss_n_pin(ss_b)
  );
  sfq_dev_model sfq_dev_model_inst (
    .i_sclk(sclk), .i_ss_n(ss_a), .i_mosi(mosi), .o_miso(d_miso),
    .i_clock_polarity_bit(clock_polarity_bit), .i_clock_phase_bit(clock_phase_bit), .i_tx(sd), .o_rx(d_rx)
  );
  task give_verdict();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task tmo(input int cnt);
    if (cnt >= LIM) begin
      n_fail++;
      give_verdict();
    end
  endtask : tmo
  task ack();
    @(posedge clk);
    mack <= 1'b1;
    sack <= 1'b1;
    @(posedge clk);
    mack <= 1'b0;
    sack <= 1'b0;
    @(negedge clk);
  endtask : ack
  // The module is disabled while the format changes.
  task cfg(input logic pol, input logic pha, input logic [1:0] rate);
    @(posedge clk);
    en <= 1'b0;
    clock_polarity_bit <= pol;
    clock_phase_bit <= pha;
    {rh, rl} <= rate;
    repeat (3) @(posedge clk);
    en <= 1'b1;
  endtask : cfg
  // Slave data is written, then select falls and master data follows; select rises after each byte.
  task run_row(input sfq_row_type r);
    int bt;
    bt = 2 << (2 * r.rate);
    cfg(r.clock_polarity_bit, r.clock_phase_bit, r.rate);
    sd <= r.stx;
    sv <= r.tgt;
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(negedge clk);
    chk(sclk, r.clock_polarity_bit); // idle
    chk({m_sclk_oe_n, m_mosi_oe_n, s_miso_oe_n}, 8'h01);
    @(posedge clk);
    ss_a <= r.tgt;
    ss_b <= !r.tgt;
    repeat (4) @(posedge clk);
    md <= r.mtx;
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    @(negedge clk);
    for (i = 0; i < bt + 4 && m_busy !== 1'b1; i++) @(negedge clk);
    chk(i < bt + 4, 1'b1); // delay
    chk(sclk, r.clock_polarity_bit ^ r.clock_phase_bit); // first half
    chk(mosi, r.mtx[7]); // MSB
    chk(m_txe, 1'b1); // freed
    chk(s_miso_oe_n, !r.tgt); // select
    for (i = 0; i < LIM && m_rxf !== 1'b1; i++) @(negedge clk);
    tmo(i);
    if (r.rate != 2'h0) chk(m_rx, r.stx); // received
    repeat (8) @(negedge clk);
    chk(r.tgt ? s_rx : d_rx, r.mtx); // duplex
    chk(s_rxf, r.tgt); // slave flag
    @(posedge clk);
    ss_a <= 1'b1;
    ss_b <= 1'b1;
    repeat (4) @(negedge clk);
    chk(s_miso_oe_n, 1'b1); // released
    ack();
  endtask : run_row
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({m_txe, m_rxf, m_busy}, 8'h04); // reset
    chk(m_rx, 8'h00); // reset
    foreach (rows[r]) run_row(rows[r]);
    // Select stays low across the whole burst.
    cfg(1'b0, 1'b1, 2'h1);
    ss_a <= 1'b0;
    acc = 0;
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      mv <= 1'b1;
      md <= 8'h10 + k[7:0];
      @(negedge clk);
      if (m_txe === 1'b1) acc++;
    end
    @(posedge clk);
    mv <= 1'b0;
    @(negedge clk);
    chk(acc, 8'h09); // queue depth
    chk(m_txe, 1'b0); // refused
    gap = 0;
    for (k = 0; k < 9; k++) begin
      for (i = 0; i < LIM && m_rxf !== 1'b1; i++) begin
        @(negedge clk);
        if (k > 0 && m_busy !== 1'b1 && m_rxf !== 1'b1) gap++;
      end
      tmo(i);
      chk(d_rx, 8'h10 + k[7:0]); // order
      ack();
    end
    chk(gap, 8'h00); // no gap
    chk(m_txe, 1'b1); // drained
    ss_a <= 1'b1;
    // A reset in mid-transfer empties the queue, clears the receive flag and busy, and sets the transmit empty flag.
    @(posedge clk);
    md <= 8'h42;
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(m_busy, 1'b1); // started
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({m_txe, m_rxf, m_busy}, 8'h04); // reset
    chk(sclk, 1'b0); // idle
    give_verdict();
  end
endmodule : tb
